/* sfp_pop_seq.sv */
`timescale 1ns/1ps
module sfp_pop_seq #(
  parameter int XW = 32                               // Register width, 32 or 64
) (
  input  wire logic               clk_sys_i,
  input  wire logic               sys_rst_i,
  input  wire sfp_pkg::sfp_base_t base_i,             // Active base variant
  input  wire logic               instr_valid_i,      // Decoded instruction offered
  input  wire logic        [15:0] instr_i,            // Compressed instruction
  input  wire logic      [XW-1:0] sp_i,               // Current stack pointer
  input  wire logic      [XW-1:0] link_i,             // Current return link value
  output logic                    instr_ready_o,      // Idle, may take one
  output logic                    ld_req_o,           // Load request
  output logic           [XW-1:0] ld_addr_o,          // Load address
  output logic              [4:0] ld_rd_o,            // Destination register
  output logic                    ld_dword_o,         // 8-byte load
  input  wire logic               ld_ack_i,           // Load finished
  input  wire logic               ld_err_i,           // Load faulted
  input  wire logic               ld_nonidem_i,       // Target not idempotent
  input  wire logic               irq_pend_i,         // Interrupt wants in
  output logic                    sp_we_o,            // Stack pointer write pulse
  output logic           [XW-1:0] sp_wdata_o,         // New stack pointer
  output logic                    zero_we_o,          // Clear x10 pulse
  output logic                    jump_o,             // Jump pulse
  output logic           [XW-1:0] jump_addr_o,        // Jump target
  output logic                    illegal_o,          // Illegal instruction pulse
  output logic                    acc_fault_o,        // Load access fault pulse
  output logic                    abort_o,            // Sequence abandoned pulse
  output logic                    done_o              // Instruction retired pulse
);
  import sfp_pkg::*;

  typedef enum logic [1:0] {
    SFP_ST_IDLE = 2'b00,
    SFP_ST_LOAD = 2'b01,
    SFP_ST_WAIT = 2'b10,
    SFP_ST_FIN  = 2'b11
  } sfp_state_t;

  localparam logic [3:0] RB = (XW == 64) ? 4'h8 : 4'h4;  // Bytes per load

  // Opcode decode
  wire       opq     = (instr_i[1:0] == SFP_OPC_QUAD);
  wire       is_pop  = opq && (instr_i[15:8] == SFP_OPC_POP);
  wire       is_retz = opq && (instr_i[15:8] == SFP_OPC_POPRETZ);
  wire [3:0] rlist   = instr_i[SFP_RLIST_LSB +: 4];
  wire [1:0] spimm   = instr_i[SFP_SPIMM_LSB +: 2];
  wire       legal;
  wire [3:0] count;
  wire [7:0] adj;

  sfp_frame_calc u_calc (
    .rlist_i (rlist),
    .spimm_i (spimm),
    .base_i  (base_i),
    .legal_o (legal),
    .count_o (count),
    .adj_o   (adj)
  );

  sfp_state_t    state_ff, nxt_state;
  logic          retz_ff;          // Return-zero variant latched
  logic    [3:0] left_ff;          // Loads not yet acknowledged
  logic    [3:0] cnt_ff;           // Total loads, for restart
  logic [XW-1:0] addr_ff;          // Next load address
  logic [XW-1:0] sp_new_ff;        // Stack pointer after release
  logic [XW-1:0] top_ff;           // First load address, for restart

  wire take    = instr_valid_i && (is_pop || is_retz) && (state_ff == SFP_ST_IDLE);
  wire bad     = take && !legal;
  wire [XW-1:0] adj_x = {{(XW-8){1'b0}}, adj};
  wire [XW-1:0] first = sp_i + adj_x - {{(XW-4){1'b0}}, RB};
  // Register visited n-th from the top, n counted from remaining loads
  wire [3:0] idx   = left_ff - 4'h1;
  wire [4:0] rd    = (idx == 4'h0) ? SFP_REG_LINK :
                     (idx == 4'h1) ? SFP_REG_S0 :
                     (idx == 4'h2) ? SFP_REG_S1 :
                     5'(SFP_REG_S2 + 5'(idx) - 5'h3);
  wire fault   = ld_ack_i && (ld_err_i || ld_nonidem_i);
  wire intr    = (state_ff == SFP_ST_WAIT) && irq_pend_i && !ld_ack_i;
  wire last_ok = ld_ack_i && !fault && (left_ff == 4'h1);

  // Sequencer next state; final phase entered only after clean last load
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SFP_ST_IDLE: if (take && legal) nxt_state = SFP_ST_LOAD;
      SFP_ST_LOAD: nxt_state = SFP_ST_WAIT;
      SFP_ST_WAIT: begin
        if (fault || intr)  nxt_state = SFP_ST_IDLE;
        else if (last_ok)   nxt_state = SFP_ST_FIN;
        else if (ld_ack_i)  nxt_state = SFP_ST_LOAD;
      end
      SFP_ST_FIN:  nxt_state = SFP_ST_IDLE;
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_ff <= SFP_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Datapath held across the sequence
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      retz_ff   <= 1'b0;
      left_ff   <= 4'h0;
      cnt_ff    <= 4'h0;
      addr_ff   <= '0;
      sp_new_ff <= '0;
      top_ff    <= '0;
    end else if (take && legal) begin
      retz_ff   <= is_retz;
      left_ff   <= count;
      cnt_ff    <= count;
      addr_ff   <= first;
      top_ff    <= first;
      sp_new_ff <= sp_i + adj_x;
    end else if ((state_ff == SFP_ST_WAIT) && ld_ack_i && !fault) begin
      left_ff   <= left_ff - 4'h1;
      addr_ff   <= addr_ff - {{(XW-4){1'b0}}, RB};
    end
  end

  // Registered outputs; final phase drives all commits in one cycle
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      instr_ready_o <= 1'b0;
      ld_req_o      <= 1'b0;
      ld_addr_o     <= '0;
      ld_rd_o       <= 5'h00;
      ld_dword_o    <= 1'b0;
      sp_we_o       <= 1'b0;
      sp_wdata_o    <= '0;
      zero_we_o     <= 1'b0;
      jump_o        <= 1'b0;
      jump_addr_o   <= '0;
      illegal_o     <= 1'b0;
      acc_fault_o   <= 1'b0;
      abort_o       <= 1'b0;
      done_o        <= 1'b0;
    end else begin
      instr_ready_o <= (nxt_state == SFP_ST_IDLE);
      ld_req_o      <= (state_ff == SFP_ST_LOAD);
      ld_addr_o     <= addr_ff;
      ld_rd_o       <= rd;
      ld_dword_o    <= (XW == 64);
      sp_we_o       <= (state_ff == SFP_ST_FIN);
      sp_wdata_o    <= sp_new_ff;
      zero_we_o     <= (state_ff == SFP_ST_FIN) && retz_ff;
      jump_o        <= (state_ff == SFP_ST_FIN) && retz_ff;
      jump_addr_o   <= link_i;
      illegal_o     <= bad;
      acc_fault_o   <= (state_ff == SFP_ST_WAIT) && fault;
      abort_o       <= (state_ff == SFP_ST_WAIT) && (fault || intr);
      done_o        <= (state_ff == SFP_ST_FIN);
    end
  end

  // Restart values pin every load to its slot in the frame, first try or retry
  a_addr_track: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_ff == SFP_ST_LOAD)
      |-> addr_ff == top_ff - {{(XW-8){1'b0}}, 8'(cnt_ff - left_ff) * 8'(RB)})
    else $error("load address off its frame slot");

  // Commit never happens while loads remain
  a_fin_after_loads: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_ff == SFP_ST_FIN) |-> (left_ff == 4'h0))
    else $error("final phase with loads outstanding");

  // Stack write one cycle after final phase
  a_sp_commit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_ff == SFP_ST_FIN) |=> sp_we_o && (sp_wdata_o == $past(sp_new_ff)))
    else $error("stack pointer not committed");

  // Zero and jump only together with stack write
  a_zero_atomic: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    zero_we_o |-> sp_we_o && jump_o)
    else $error("zeroing outside atomic phase");

  // Plain pop never jumps
  a_plain_nojump: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_ff == SFP_ST_FIN) && !retz_ff |=> !jump_o)
    else $error("plain pop jumped");

  // Reserved code flagged next cycle, no load
  a_illegal_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    take && (rlist < SFP_RLIST_MIN) |=> illegal_o ##1 !ld_req_o)
    else $error("reserved list code accepted");

  // Address steps down one register width
  a_addr_step: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_ff == SFP_ST_WAIT) && ld_ack_i && !fault && !last_ok
      |=> addr_ff == $past(addr_ff) - {{(XW-4){1'b0}}, RB})
    else $error("load address step wrong");

  // Load width follows register width
  a_load_width: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ld_req_o |-> (ld_dword_o == (XW == 64)))
    else $error("load width wrong");

  // Fault abandons without commit
  a_fault_abort: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_ff == SFP_ST_WAIT) && fault |=> abort_o ##1 !sp_we_o)
    else $error("fault did not abort");

  // Reduced base rejects code seven upward
  a_reduced_codes: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    take && (base_i == SFP_BASE_RED32) && (rlist > SFP_RLIST_MAX_RED) |=> illegal_o)
    else $error("reduced base accepted large code");

endmodule : sfp_pop_seq

/* sfp_pkg.sv */
package sfp_pkg;

  // Opcode fields of the two pop encodings (bits 15:8, bits 1:0)
  localparam logic [7:0] SFP_OPC_POP     = 8'hBA;  // 1011_1010
  localparam logic [7:0] SFP_OPC_POPRETZ = 8'hBC;  // 1011_1100
  localparam logic [1:0] SFP_OPC_QUAD    = 2'h2;

  // Instruction field positions
  localparam int SFP_RLIST_LSB = 4;
  localparam int SFP_SPIMM_LSB = 2;

  // Register numbers touched by the sequence
  localparam logic [4:0] SFP_REG_LINK = 5'h01;
  localparam logic [4:0] SFP_REG_ARG0 = 5'h0A;
  localparam logic [4:0] SFP_REG_S0   = 5'h08;
  localparam logic [4:0] SFP_REG_S1   = 5'h09;
  localparam logic [4:0] SFP_REG_S2   = 5'h12;

  // List code limits
  localparam logic [3:0] SFP_RLIST_MIN     = 4'h4;
  localparam logic [3:0] SFP_RLIST_MAX_RED = 4'h6;

  // Frame granule in bytes
  localparam int SFP_FRAME_GRAIN = 16;

  // Base variants
  typedef enum logic [1:0] {
    SFP_BASE_RED32  = 2'b00,
    SFP_BASE_FULL32 = 2'b01,
    SFP_BASE_WIDE64 = 2'b10
  } sfp_base_t;

endpackage : sfp_pkg

/* sfp_frame_calc.sv */
`timescale 1ns/1ps
// Decodes list code into register count and frame size in bytes
module sfp_frame_calc (
  input  wire logic              [3:0] rlist_i,
  input  wire logic              [1:0] spimm_i,
  input  wire sfp_pkg::sfp_base_t      base_i,
  output logic                         legal_o,
  output logic                   [3:0] count_o,
  output logic                   [7:0] adj_o
);
  import sfp_pkg::*;

  wire        is_wide  = (base_i == SFP_BASE_WIDE64);
  wire        is_red   = (base_i == SFP_BASE_RED32);
  // Codes below four are reserved in every variant
  wire        code_ok  = (rlist_i >= SFP_RLIST_MIN);
  // Reduced base stops at code six
  wire        red_ok   = !is_red || (rlist_i <= SFP_RLIST_MAX_RED);
  // Code 15 loads thirteen registers; 14 loads eleven
  wire  [3:0] raw_cnt  = rlist_i - 4'h3;
  wire  [3:0] cnt      = (rlist_i == 4'hF) ? 4'hD : raw_cnt;
  // Bytes per register: 4 or 8
  wire  [7:0] bytes    = {4'h0, cnt} << (is_wide ? 3 : 2);
  // Round up to 16-byte granule
  wire  [7:0] base_sz  = is_red ? 8'h10 : ((bytes + 8'h0F) & 8'hF0);
  // Extra space in 16-byte steps
  wire  [7:0] extra    = {2'h0, spimm_i, 4'h0};

  assign legal_o = code_ok && red_ok;
  assign count_o = cnt;
  assign adj_o   = base_sz + extra;

endmodule : sfp_frame_calc

/* sfp_mem_model.sv */
`timescale 1ns/1ps
// Load port of the hart: answers each load after a set wait
module sfp_mem_model (
  input  wire logic       clk_sys_i,
  input  wire logic       sys_rst_i,
  input  wire logic       ld_req_i,   // Load request pulse
  input  wire logic       clr_i,      // New instruction offered
  input  wire logic [1:0] dly_i,      // Extra wait cycles
  input  wire logic [3:0] bad_i,      // Index of load that faults
  input  wire logic       nid_i,      // Fault as non-idempotent
  output logic            ack_o,
  output logic            err_o,
  output logic            nonidem_o
);
  logic [3:0] num_ff;   // Loads seen in this instruction
  logic [2:0] wait_ff;  // Cycles to answer, 0 when idle
  logic       hit;      // This answer carries the fault
  assign hit = (wait_ff == 3'h1) && (num_ff == bad_i + 4'h1);
  // Qualifiers toggle outside an answer, so stale values never look valid
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || clr_i) begin
      num_ff    <= 4'h0;
      wait_ff   <= 3'h0;
      ack_o     <= 1'b0;
      err_o     <= 1'b0;
      nonidem_o <= 1'b0;
    end else begin
      ack_o     <= (wait_ff == 3'h1);
      err_o     <= (wait_ff == 3'h1) ? (hit && !nid_i) : ~err_o;
      nonidem_o <= (wait_ff == 3'h1) ? (hit && nid_i) : ~nonidem_o;
      if (ld_req_i) begin
        num_ff  <= num_ff + 4'h1;
        wait_ff <= {1'b0, dly_i} + 3'h1;
      end else if (wait_ff != 3'h0) begin
        wait_ff <= wait_ff - 3'h1;
      end
    end
  end
endmodule : sfp_mem_model

/* tb_stack_frame_pop_sequencer.sv */
`timescale 1ns/1ps
module tb_stack_frame_pop_sequencer;
  import sfp_pkg::*;
  localparam logic [31:0] SP0  = 32'h0000_8000;  // Stack pointer offered
  localparam logic [31:0] LINK = 32'h0000_1234;  // Reloaded link value
  localparam logic [31:0] STALE = 32'h0000_5A5A;  // Link value before x1 is reloaded
  logic [31:0] sp_q = SP0, link_q = STALE;  // Stack pointer and link as the core shows them
  logic clk_sys_i = 0, sys_rst_i = 1, instr_valid_i = 0, irq_pend_i = 0, nid_q = 0;
  logic [15:0] instr_i = 16'h0000;
  logic [1:0]  dly_q = 2'h0;
  logic [3:0]  bad_q = 4'hF;
  sfp_base_t   base_i = SFP_BASE_FULL32;
  logic instr_ready_o, ld_req_o, ld_dword_o, ld_ack_i, ld_err_i, ld_nonidem_i;
  logic sp_we_o, zero_we_o, jump_o, illegal_o, acc_fault_o, abort_o, done_o;
  logic [31:0] ld_addr_o, sp_wdata_o, jump_addr_o;
  logic [4:0]  ld_rd_o;
  int num_errors = 0, n_checks = 0, cyc = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  sfp_pop_seq #(.XW(32)) u_dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .base_i(base_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .sp_i(sp_q), .link_i(link_q),
    .instr_ready_o(instr_ready_o), .ld_req_o(ld_req_o), .ld_addr_o(ld_addr_o),
    .ld_rd_o(ld_rd_o), .ld_dword_o(ld_dword_o), .ld_ack_i(ld_ack_i), .ld_err_i(ld_err_i),
    .ld_nonidem_i(ld_nonidem_i), .irq_pend_i(irq_pend_i), .sp_we_o(sp_we_o),
    .sp_wdata_o(sp_wdata_o), .zero_we_o(zero_we_o), .jump_o(jump_o),
    .jump_addr_o(jump_addr_o), .illegal_o(illegal_o), .acc_fault_o(acc_fault_o),
    .abort_o(abort_o), .done_o(done_o));
  sfp_mem_model u_mem (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ld_req_i(ld_req_o),
    .clr_i(instr_valid_i), .dly_i(dly_q), .bad_i(bad_q), .nid_i(nid_q), .ack_o(ld_ack_i),
    .err_o(ld_err_i), .nonidem_o(ld_nonidem_i));
  // Same sequencer at 64-bit width, offered only full-base instructions; it must keep step
  logic w_ready, w_req, w_dword, w_sp_we, w_zero, w_jump, w_ill, w_acc, w_abort, w_done;
  logic wide = 1'b0;
  logic [63:0] w_addr, w_sp_wdata, w_jump_addr;
  logic [4:0]  w_rd;
  wire         w_valid = instr_valid_i && wide;
  sfp_pop_seq #(.XW(64)) u_dut_wide (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .base_i(SFP_BASE_WIDE64), .instr_valid_i(w_valid), .instr_i(instr_i),
    .sp_i({32'h0000_0000, sp_q}), .link_i({32'h0000_0000, link_q}),
    .instr_ready_o(w_ready), .ld_req_o(w_req), .ld_addr_o(w_addr), .ld_rd_o(w_rd),
    .ld_dword_o(w_dword), .ld_ack_i(ld_ack_i), .ld_err_i(ld_err_i),
    .ld_nonidem_i(ld_nonidem_i), .irq_pend_i(irq_pend_i), .sp_we_o(w_sp_we),
    .sp_wdata_o(w_sp_wdata), .zero_we_o(w_zero), .jump_o(w_jump),
    .jump_addr_o(w_jump_addr), .illegal_o(w_ill), .acc_fault_o(w_acc),
    .abort_o(w_abort), .done_o(w_done));
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      results();
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  // Destination of the k-th load: high saved registers first, then x9, x8, x1
  function automatic logic [4:0] exp_rd(input int cnt, input int k);
    int s;
    logic [4:0] low [3];
    s = (cnt > 3) ? cnt - 3 : 0;
    low = '{5'h09, 5'h08, 5'h01};
    if (k < s) return 5'(18 + s - 1 - k);
    return low[k - s + 3 - (cnt - s)];
  endfunction : exp_rd
  // One instruction from offer to retire, abort or refusal
  task automatic exec(input logic [7:0] opc, input sfp_base_t b, input int code,
                      input int imm, input int bad, input logic nid, input logic irq);
    int cnt, adj, adw, nld, i;
    logic ill_exp, ill, fin, flt, abt, rz;
    ill_exp = (code < 4) || (b == SFP_BASE_RED32 && code > 6);
    cnt = (code == 15) ? 13 : code - 3;
    adj = ((cnt * 4 + 15) / 16) * 16 + imm * 16;
    adw = ((cnt * 8 + 15) / 16) * 16 + imm * 16;
    rz = (opc == SFP_OPC_POPRETZ);
    nld = 0;
    ill = 1'b0;
    fin = 1'b0;
    flt = 1'b0;
    abt = 1'b0;
    for (i = 0; i < 50 && instr_ready_o !== 1'b1; i++) @(negedge clk_sys_i);
    chk(instr_ready_o === 1'b1, "not ready for next instruction");
    base_i = b;
    wide = (b == SFP_BASE_FULL32);
    bad_q = 4'(bad);
    nid_q = nid;
    sp_q = SP0;
    link_q = STALE;
    instr_i = {opc, 4'(code), 2'(imm), SFP_OPC_QUAD};
    instr_valid_i = 1'b1;
    @(negedge clk_sys_i);
    instr_valid_i = 1'b0;
    // Changes after the take must not reach the running instruction
    instr_i = 16'h0000;
    sp_q = SP0 ^ 32'h0000_0F00;
    for (i = 0; i < 200 && !fin; i++) begin
      irq_pend_i = 1'b0;
      if (wide && {w_ready, w_req, w_ill, w_acc, w_abort, w_done, w_sp_we, w_jump} !==
          {instr_ready_o, ld_req_o, illegal_o, acc_fault_o, abort_o, done_o, sp_we_o, jump_o})
        chk(1'b0, "wide sequencer out of step");
      if (ld_req_o === 1'b1) begin
        chk(instr_ready_o === 1'b0, "ready while loading");
        chk(ld_addr_o === 32'(SP0 + adj - 4 - 4 * nld), "load address");
        chk(ld_rd_o === exp_rd(cnt, nld) && ld_dword_o === 1'b0, "load kind");
        if (wide) chk(w_addr === 64'(SP0 + adw - 8 - 8 * nld), "wide address");
        if (wide) chk(w_rd === exp_rd(cnt, nld) && w_dword === 1'b1, "wide load kind");
        nld++;
        irq_pend_i = irq;
      end
      // The last load answered is x1: the core now shows the reloaded link
      if (ld_ack_i === 1'b1 && ld_err_i === 1'b0 && nld == cnt) link_q = LINK;
      if (done_o === 1'b1) begin
        chk(sp_we_o === 1'b1 && sp_wdata_o === 32'(SP0 + adj), "stack pointer");
        chk(zero_we_o === rz && jump_o === rz, "return kind");
        if (rz) chk(jump_addr_o === LINK, "jump target");
        if (wide) chk(w_sp_wdata === 64'(SP0 + adw), "wide commit");
        if (wide && rz) chk(w_jump_addr === 64'(LINK) && w_zero === 1'b1, "wide return");
        fin = 1'b1;
      end else if (sp_we_o === 1'b1) chk(1'b0, "stray commit");
      if (illegal_o === 1'b1) {ill, fin} = 2'b11;
      if (acc_fault_o === 1'b1) flt = 1'b1;
      if (abort_o === 1'b1) {abt, fin} = 2'b11;
      @(negedge clk_sys_i);
    end
    irq_pend_i = 1'b0;
    chk(ill === ill_exp, "illegal flag");
    if (ill_exp) chk(nld == 0, "loads on reserved code");
    else if (bad < 13) chk(flt && abt && nld == bad + 1, "fault abort");
    else if (irq) chk(abt && !flt && nld == 1, "interrupt abort");
    else chk(fin && !abt && nld == cnt, "load count");
  endtask : exec
  task automatic t_reserved;
    for (int c = 0; c < 4; c++) begin
      exec(SFP_OPC_POP, SFP_BASE_FULL32, c, 0, 15, 0, 0);
      exec(SFP_OPC_POPRETZ, SFP_BASE_RED32, c, 1, 15, 0, 0);
    end
    exec(SFP_OPC_POP, SFP_BASE_RED32, 7, 0, 15, 0, 0);
    exec(SFP_OPC_POPRETZ, SFP_BASE_RED32, 15, 0, 15, 0, 0);
    $display("test reserved done");
  endtask : t_reserved
  // Neighbouring encodings and another quadrant pass by without any response
  task automatic t_foreign;
    int i;
    logic seen;
    seen = 1'b0;
    base_i = SFP_BASE_FULL32;
    wide = 1'b1;
    for (i = 0; i < 3; i++) begin
      instr_i = (i == 0) ? 16'hBE42 : (i == 1) ? 16'hBA41 : 16'hB842;
      instr_valid_i = 1'b1;
      @(negedge clk_sys_i);
      instr_valid_i = 1'b0;
      repeat (4) begin
        seen = seen | ld_req_o | illegal_o | ~instr_ready_o | w_req | w_ill | ~w_ready;
        @(negedge clk_sys_i);
      end
    end
    chk(seen === 1'b0, "foreign encoding acted on");
    $display("test foreign done");
  endtask : t_foreign
  task automatic t_reduced;
    for (int c = 4; c < 7; c++)
      for (int m = 0; m < 4; m++)
        exec(c[0] ? SFP_OPC_POP : SFP_OPC_POPRETZ, SFP_BASE_RED32, c, m, 15, 0, 0);
    $display("test reduced done");
  endtask : t_reduced
  task automatic t_full;
    for (int c = 4; c < 16; c++)
      exec(c[0] ? SFP_OPC_POP : SFP_OPC_POPRETZ, SFP_BASE_FULL32, c, c % 4, 15, 0, 0);
    $display("test full done");
  endtask : t_full
  task automatic t_fault;
    dly_q = 2'h1;
    exec(SFP_OPC_POP, SFP_BASE_FULL32, 8, 1, 2, 0, 0);
    exec(SFP_OPC_POPRETZ, SFP_BASE_FULL32, 15, 3, 0, 1, 0);
    dly_q = 2'h0;
    $display("test fault done");
  endtask : t_fault
  task automatic t_irq;
    dly_q = 2'h3;
    exec(SFP_OPC_POPRETZ, SFP_BASE_FULL32, 10, 2, 15, 0, 1);
    exec(SFP_OPC_POPRETZ, SFP_BASE_FULL32, 10, 2, 15, 0, 0);
    dly_q = 2'h0;
    $display("test irq done");
  endtask : t_irq
  initial begin
    repeat (10) @(negedge clk_sys_i);
    sys_rst_i = 1'b0;
    t_reserved();
    t_foreign();
    t_reduced();
    t_full();
    t_fault();
    t_irq();
    results();
  end
endmodule : tb_stack_frame_pop_sequencer
